/* src/blit_pkg.sv */
// blit_pkg: register map, field layout and codes for the blit command decoder
// assumes: APB slave with 32-bit data, one system clock
package blit_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [15:0] CONTROL_OFS      = 16'h8000;
  localparam logic [15:0] STATUS_OFS       = 16'h8004;
  localparam logic [15:0] COMMAND_OFS      = 16'h8008;
  localparam logic [15:0] SOURCE_START_OFS = 16'h800C;
  localparam logic [15:0] FIFO_POP_OFS     = 16'h8040;

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int          GO_BIT        = 0;
  localparam int          DEPTH_BIT     = 18;
  localparam int          BUSY_BIT      = 0;
  localparam int          ROP_LSB       = 16;
  localparam int          OP_LSB        = 0;
  localparam int          ADDR_W        = 21;
  localparam logic [31:0] COMMAND_RST   = 32'h0000_0000;
  localparam logic [31:0] SOURCE_RST    = 32'h0000_0000;
  localparam logic [31:0] CONTROL_MASK  = 32'h0004_0000;
  localparam logic [31:0] COMMAND_MASK  = 32'h000F_000F;
  localparam logic [31:0] SOURCE_MASK   = 32'h001F_FFFF;

  // ----------------------------------------------------------------
  // read-transfer fifo throttle and transfer length
  // ----------------------------------------------------------------
  localparam logic [4:0] FIFO_FULL_CNT    = 5'h10;
  localparam logic [4:0] FIFO_RESUME_CNT  = 5'h0E;
  localparam logic [7:0] XFER_LEN         = 8'h20;

  // ----------------------------------------------------------------
  // operation codes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_WRITE_ROP     = 4'h0,
    OP_READ          = 4'h1,
    OP_MOVE_POS_ROP  = 4'h2,
    OP_MOVE_NEG_ROP  = 4'h3,
    OP_WRITE_TRANSP  = 4'h4,
    OP_MOVE_TRANSP   = 4'h5,
    OP_PATTERN_ROP   = 4'h6,
    OP_PATTERN_TRANSP= 4'h7,
    OP_EXPAND        = 4'h8,
    OP_EXPAND_TRANSP = 4'h9,
    OP_MOVE_EXPAND   = 4'hA,
    OP_MOVE_EXPAND_T = 4'hB,
    OP_SOLID_FILL    = 4'hC
  } op_t;

  localparam logic [3:0] OP_LAST_LEGAL = 4'hC;

endpackage : blit_pkg

/* src/blit_command_decode.sv */
// blit_command_decode: command/source decode and pixel raster unit
// assumes: APB master on sys_clk_i; pixel operands come from the datapath
`timescale 1ns/1ns
`default_nettype none

module blit_command_decode
(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [15:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic [15:0] src_pixel_i,
  input  wire logic [15:0] pat_pixel_i,
  input  wire logic [15:0] dst_pixel_i,
  input  wire logic [15:0] key_colour_i,
  input  wire logic        pixel_valid_i,
  output logic      [15:0] result_pixel_o,
  output logic             result_write_o,
  output logic             transfer_active_o,
  output logic      [3:0]  transfer_operation_select_o,
  output logic      [2:0]  expand_start_bit_o,
  output logic             host_sourced_o,
  output logic             odd_byte_align_o,
  output logic      [14:0] pattern_base_o,
  output logic      [2:0]  pattern_line_o,
  output logic      [3:0]  pattern_pixel_o,
  output logic             fifo_push_o
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0] blit_control;
  logic [31:0] blit_command;
  logic [31:0] blit_source_start;
  logic [4:0]  fifo_used;
  logic [7:0]  remaining;
  logic        paused;

  // busy is the state itself, so status can never disagree with it
  typedef enum logic [1:0] {IDLE, RUN} eng_state_t;
  eng_state_t state;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire logic access     = psel_i & penable_i;
  wire logic wr         = access & pwrite_i;
  wire logic rd         = access & ~pwrite_i;
  wire logic hit_ctrl   = paddr_i == blit_pkg::CONTROL_OFS;
  wire logic hit_stat   = paddr_i == blit_pkg::STATUS_OFS;
  wire logic hit_cmd    = paddr_i == blit_pkg::COMMAND_OFS;
  wire logic hit_src    = paddr_i == blit_pkg::SOURCE_START_OFS;
  wire logic hit_pop    = paddr_i == blit_pkg::FIFO_POP_OFS;
  wire logic mapped     = hit_ctrl | hit_stat | hit_cmd | hit_src | hit_pop;
  wire logic busy       = state == RUN;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  wire logic [3:0] op_sel   = blit_command[blit_pkg::OP_LSB +: 4];
  wire logic [3:0] rop_code = blit_command[blit_pkg::ROP_LSB +: 4];
  wire logic       depth16  = blit_control[blit_pkg::DEPTH_BIT];
  wire logic       reserved = op_sel > blit_pkg::OP_LAST_LEGAL;
  wire logic       go_write = wr & hit_ctrl & pwdata_i[blit_pkg::GO_BIT];
  // writing zero to go never stops a run: no clear path exists
  wire logic       start    = go_write & ~busy;

  wire logic is_read    = op_sel == blit_pkg::OP_READ;
  wire logic is_pattern = op_sel == blit_pkg::OP_PATTERN_ROP
                        | op_sel == blit_pkg::OP_PATTERN_TRANSP;
  wire logic is_transp  = op_sel == blit_pkg::OP_WRITE_TRANSP
                        | op_sel == blit_pkg::OP_MOVE_TRANSP
                        | op_sel == blit_pkg::OP_PATTERN_TRANSP
                        | op_sel == blit_pkg::OP_EXPAND_TRANSP
                        | op_sel == blit_pkg::OP_MOVE_EXPAND_T;
  wire logic is_solid   = op_sel == blit_pkg::OP_SOLID_FILL;
  wire logic is_expand  = op_sel[3:2] == 2'b10;
  // write ops and the two non-move expand ops (8, 9) take their data from the host
  wire logic host_src   = op_sel == blit_pkg::OP_WRITE_ROP
                        | op_sel == blit_pkg::OP_WRITE_TRANSP
                        | op_sel == blit_pkg::OP_EXPAND
                        | op_sel == blit_pkg::OP_EXPAND_TRANSP;

  // ----------------------------------------------------------------
  // pattern address split
  // ----------------------------------------------------------------
  wire logic [20:0] src_addr = blit_source_start[20:0];
  wire logic [14:0] next_base = depth16
    ? {1'b0, src_addr[20:7]}
    : src_addr[20:6];
  wire logic [2:0]  next_line = depth16 ? src_addr[6:4] : src_addr[5:3];
  wire logic [3:0]  next_pix  = depth16 ? src_addr[3:0]
                                        : {1'b0, src_addr[2:0]};

  // ----------------------------------------------------------------
  // raster function
  // ----------------------------------------------------------------
  // pattern replaces source operand
  wire logic [15:0] s_opnd = is_pattern ? pat_pixel_i : src_pixel_i;
  wire logic [15:0] d_opnd = dst_pixel_i;
  logic [15:0] rop_out;
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++)
    begin : g_rop
      // truth table index {s,d} bitwise per pixel bit
      assign rop_out[gi] = rop_code[{s_opnd[gi], d_opnd[gi]}];
    end
  endgenerate
  wire logic [15:0] depth_mask = depth16 ? 16'hFFFF : 16'h00FF;
  wire logic [15:0] next_result = (is_solid ? s_opnd : rop_out) & depth_mask;
  wire logic key_hit = ((s_opnd ^ key_colour_i) & depth_mask) == 16'h0000;

  // ----------------------------------------------------------------
  // read throttle
  // ----------------------------------------------------------------
  wire logic pop      = wr & hit_pop & fifo_used != 5'h00;
  // two-entry hysteresis stops the engine trickling single words
  wire logic full     = fifo_used == blit_pkg::FIFO_FULL_CNT;
  // after full, wait until fewer than 14 remain
  wire logic next_paused = paused
    ? fifo_used >= blit_pkg::FIFO_RESUME_CNT
    : full;
  wire logic push     = busy & is_read & ~next_paused & ~full
                      & remaining != 8'h00;
  wire logic done     = busy & (reserved
                      | (is_read & remaining == 8'h00)
                      | (~is_read & remaining == 8'h00));
  wire logic pix_step = busy & ~is_read & ~reserved & pixel_valid_i
                      & remaining != 8'h00;
  // a write only rides on a counted step, so a run writes at most its
  // fixed XFER_LEN pixels and a reserved code never reaches memory
  wire logic next_wr  = pix_step & ~(is_transp & key_hit);

  wire logic [31:0] status_word = {3'h0, fifo_used, 23'h0, busy};
  wire logic [31:0] rd_word =
      hit_ctrl ? (blit_control & blit_pkg::CONTROL_MASK)
    : hit_stat ? status_word
    : hit_cmd  ? blit_command
    : hit_src  ? blit_source_start
    : 32'h0000_0000;

  // ----------------------------------------------------------------
  // sequential
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      blit_control      <= 32'h0000_0000;
      blit_command      <= blit_pkg::COMMAND_RST;
      blit_source_start <= blit_pkg::SOURCE_RST;
    end
    else if (wr & hit_ctrl)
      blit_control <= pwdata_i & blit_pkg::CONTROL_MASK;
    else if (wr & hit_cmd)
      blit_command <= pwdata_i & blit_pkg::COMMAND_MASK;
    else if (wr & hit_src)
      blit_source_start <= pwdata_i & blit_pkg::SOURCE_MASK;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      state     <= IDLE;
      remaining <= 8'h00;
      fifo_used <= 5'h00;
      paused    <= 1'b0;
    end
    else
    begin
      paused <= busy & next_paused;
      fifo_used <= fifo_used + {4'h0, push} - {4'h0, pop};
      unique case (state)
        IDLE:
        begin
          if (start)
          begin
            state     <= RUN;
            remaining <= blit_pkg::XFER_LEN;
          end
        end
        RUN:
        begin
          if (done)
            state <= IDLE;
          else if (push | pix_step)
            remaining <= remaining - 8'h01;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      prdata_o                    <= 32'h0000_0000;
      pready_o                    <= 1'b0;
      pslverr_o                   <= 1'b0;
      result_pixel_o              <= 16'h0000;
      result_write_o              <= 1'b0;
      transfer_active_o           <= 1'b0;
      transfer_operation_select_o <= 4'h0;
      expand_start_bit_o          <= 3'h0;
      host_sourced_o              <= 1'b0;
      odd_byte_align_o            <= 1'b0;
      pattern_base_o              <= 15'h0000;
      pattern_line_o              <= 3'h0;
      pattern_pixel_o             <= 4'h0;
      fifo_push_o                 <= 1'b0;
    end
    else
    begin
      // no wait states: every access ends in its first access cycle
      pready_o       <= psel_i & ~penable_i;
      pslverr_o      <= psel_i & ~penable_i & ~mapped;
      prdata_o       <= (psel_i & ~penable_i & ~pwrite_i) ? rd_word
                                                          : 32'h0000_0000;
      result_pixel_o <= next_result;
      result_write_o <= next_wr;
      transfer_active_o <= (busy & ~done) | start;
      transfer_operation_select_o <= op_sel;
      expand_start_bit_o <= is_expand ? rop_code[2:0] : 3'h0;
      host_sourced_o   <= host_src;
      odd_byte_align_o <= host_src & src_addr[0];
      pattern_base_o   <= next_base;
      pattern_line_o   <= next_line;
      pattern_pixel_o  <= next_pix;
      fifo_push_o      <= push;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_NO_PUSH_WHEN_FULL: assert property (@(posedge sys_clk_i)
    disable iff (rst_i) full |-> !push)
    else $error("push while fifo full");
  AST_RESUME_BELOW: assert property (@(posedge sys_clk_i)
    disable iff (rst_i) paused && fifo_used >= 5'h0E |=> !fifo_push_o)
    else $error("resumed before fifo drained below 14");
  AST_BUSY_SET: assert property (@(posedge sys_clk_i)
    disable iff (rst_i) start |=> transfer_active_o)
    else $error("busy not raised on start");
  AST_RESERVED_DONE: assert property (@(posedge sys_clk_i)
    disable iff (rst_i) busy && reserved |=> !busy ##1 !transfer_active_o)
    else $error("reserved op did not finish at once");
  AST_EXPAND_START: assert property (@(posedge sys_clk_i)
    disable iff (rst_i) is_expand |=> expand_start_bit_o == $past(rop_code[2:0]))
    else $error("expansion start bit wrong");
  AST_SPLIT16: assert property (@(posedge sys_clk_i)
    disable iff (rst_i) depth16 |=> pattern_line_o == $past(src_addr[6:4]))
    else $error("16 bpp line split wrong");
  AST_SPLIT8: assert property (@(posedge sys_clk_i)
    disable iff (rst_i) !depth16 |=> pattern_base_o == $past(src_addr[20:6]))
    else $error("8 bpp base split wrong");
  AST_TRANSP_SKIP: assert property (@(posedge sys_clk_i)
    disable iff (rst_i) is_transp && key_hit |=> !result_write_o)
    else $error("key colour pixel written");
  AST_ZERO_GO: assert property (@(posedge sys_clk_i)
    disable iff (rst_i) busy && !done && wr && hit_ctrl |=> busy)
    else $error("run stopped early");

  // ----------------------------------------------------------------
  // decode and datapath checks
  // ----------------------------------------------------------------
  AST_READ_NO_WRITE: assert property (@(posedge sys_clk_i)
    disable iff (rst_i) busy && is_read |=> !result_write_o)
    else $error("read transfer wrote a pixel");
  AST_RESERVED_NO_WRITE: assert property (@(posedge sys_clk_i)
    disable iff (rst_i) reserved |=> !result_write_o)
    else $error("reserved op wrote a pixel");
  AST_HOST_ALIGN: assert property (@(posedge sys_clk_i)
    disable iff (rst_i) host_src |=> odd_byte_align_o == $past(src_addr[0]))
    else $error("host byte alignment wrong");
  AST_OTHER_ALIGN: assert property (@(posedge sys_clk_i)
    disable iff (rst_i) !host_src |=> !odd_byte_align_o)
    else $error("alignment shown for memory source");
  AST_PIX8: assert property (@(posedge sys_clk_i)
    disable iff (rst_i)
    !depth16 |=> pattern_pixel_o == {1'b0, $past(src_addr[2:0])})
    else $error("8 bpp pixel offset wrong");
  AST_PIX16: assert property (@(posedge sys_clk_i)
    disable iff (rst_i)
    depth16 |=> pattern_pixel_o == $past(src_addr[3:0]))
    else $error("16 bpp pixel offset wrong");
  AST_MASK8: assert property (@(posedge sys_clk_i)
    disable iff (rst_i) !depth16 |=> result_pixel_o[15:8] == 8'h00)
    else $error("upper byte set at 8 bpp");
  AST_PUSH_READ: assert property (@(posedge sys_clk_i)
    disable iff (rst_i) fifo_push_o
    |-> transfer_operation_select_o == blit_pkg::OP_READ)
    else $error("fifo push outside a read transfer");
  AST_GO_STARTS: assert property (@(posedge sys_clk_i)
    disable iff (rst_i) start |=> busy)
    else $error("go did not start an idle engine");
  AST_ROP_ZERO: assert property (@(posedge sys_clk_i)
    disable iff (rst_i) rop_code == 4'h0 && !is_solid
    |=> result_pixel_o == 16'h0000)
    else $error("raster code 0000 not all zeros");
  AST_ROP_ONE: assert property (@(posedge sys_clk_i)
    disable iff (rst_i) rop_code == 4'hF && !is_solid
    |=> result_pixel_o == $past(depth_mask))
    else $error("raster code 1111 not all ones");

  // ----------------------------------------------------------------
  // coverage
  // ----------------------------------------------------------------
  COV_READ_PAUSE: cover property (@(posedge sys_clk_i) paused ##1 !paused);
  COV_PATTERN: cover property (@(posedge sys_clk_i) busy && is_pattern);
  COV_RESERVED: cover property (@(posedge sys_clk_i) start && reserved);
  COV_KEY_SKIP: cover property (@(posedge sys_clk_i) busy && is_transp && key_hit);
  COV_EXPAND: cover property (@(posedge sys_clk_i) busy && is_expand);

endmodule : blit_command_decode

`default_nettype wire

/* tb/blit_pixel_source.sv */
// blit_pixel_source: pixel datapath stand-in that feeds operand pixels
// assumes: one clock; the bench chooses the pace and the key colour mode
`timescale 1ns/1ns
`default_nettype none

module blit_pixel_source
(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  input  wire logic        slow_i,
  input  wire logic        key_match_i,
  output logic      [15:0] src_pixel_o,
  output logic      [15:0] pat_pixel_o,
  output logic      [15:0] dst_pixel_o,
  output logic      [15:0] key_colour_o,
  output logic             pixel_valid_o
);
  logic [15:0] next_src;

  initial
  begin
    {src_pixel_o, pat_pixel_o, dst_pixel_o, key_colour_o} = 64'h0;
    pixel_valid_o = 1'b0;
  end

  // fresh operands every cycle, so a stale value never passes for a match
  always @(posedge sys_clk_i)
  begin
    next_src = 16'($urandom());
    src_pixel_o <= next_src;
    pat_pixel_o <= 16'($urandom());
    dst_pixel_o <= 16'($urandom());
    // inverted key can never match, even on the low byte
    key_colour_o <= key_match_i ? next_src : ~next_src;
    pixel_valid_o <= !rst_i && (!slow_i || $urandom_range(1) == 1);
  end
endmodule : blit_pixel_source
`default_nettype wire

/* tb/tb_blit_command_decode.sv */
// tb_blit_command_decode: self-checking bench, apb master plus pixel model
// assumes: blit_pixel_source feeds operands; pready may come in any of the first 49 access cycles
`timescale 1ns/1ns
`default_nettype none

module tb_blit_command_decode;
  logic        clk, rst, psel, pen, pwr, slow, kmatch;
  logic [15:0] paddr, src, pat, dst, key, res, exp_prev;
  logic [31:0] pwdata, prdata, rd;
  logic        rdy, err, pv, rw, busy, hs, odd, push, e;
  logic [3:0]  op_o, ppix;
  logic [2:0]  xs, pline;
  logic [14:0] pbase;
  logic [31:0] sa;
  int          errors, n_tests, nwr, npush, m_op, m_rop, m_d16;
  int          m_rop_list[3] = '{0, 15, 8};

  blit_command_decode dut (.sys_clk_i(clk), .rst_i(rst), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(rdy), .pslverr_o(err), .src_pixel_i(src),
    .pat_pixel_i(pat), .dst_pixel_i(dst), .key_colour_i(key),
    .pixel_valid_i(pv), .result_pixel_o(res), .result_write_o(rw),
    .transfer_active_o(busy), .transfer_operation_select_o(op_o),
    .expand_start_bit_o(xs), .host_sourced_o(hs), .odd_byte_align_o(odd),
    .pattern_base_o(pbase), .pattern_line_o(pline),
    .pattern_pixel_o(ppix), .fifo_push_o(push));

  blit_pixel_source partner (.sys_clk_i(clk), .rst_i(rst), .slow_i(slow),
    .key_match_i(kmatch), .src_pixel_o(src), .pat_pixel_o(pat),
    .dst_pixel_o(dst), .key_colour_o(key), .pixel_valid_o(pv));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic stop_test();
    $display("errors %0d comparisons %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test

  task automatic chk_reg(string nm, logic [31:0] ex, logic [31:0] got);
    n_tests++;
    if (got !== ex)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk_reg

  task automatic chk_pix(logic [15:0] ex, logic [15:0] got);
    n_tests++;
    if (got !== ex)
    begin
      errors++;
      $display("CHECK FAILED result_pixel expected %h seen %h", ex, got);
    end
  endtask : chk_pix

  // request held until pready is seen high at a rising edge
  task automatic apb(logic w, logic [15:0] a, logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end while (rdy !== 1'b1 && k < 50);
    if (k >= 50)
    begin
      errors++;
      stop_test();
    end
    rd = prdata;
    e = err;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  task automatic wait_idle();
    int k;
    for (k = 0; k < 3000 && busy !== 1'b0; k++)
      @(negedge clk);
    if (k >= 3000)
    begin
      errors++;
      stop_test();
    end
  endtask : wait_idle

  function automatic logic [15:0] model(logic [15:0] s, p, d);
    logic [15:0] r;
    logic [15:0] x;
    logic [3:0]  t;
    x = (m_op == 6) ? p : s;
    t = m_rop[3:0];
    for (int b = 0; b < 16; b++)
      r[b] = t[{x[b], d[b]}];
    if (m_op == 12)
      r = s;
    return m_d16 ? r : (r & 16'h00FF);
  endfunction : model

  // a registered result belongs to the operands of the edge before
  always @(posedge clk)
  begin
    npush += (push === 1'b1);
    if (rw === 1'b1)
    begin
      nwr++;
      if (m_op inside {0, 2, 3, 6, 12})
        chk_pix(exp_prev, res);
    end
    exp_prev = model(src, pat, dst);
  end

  task automatic start(int op, int rop, int d16);
    sa = 32'($urandom()) & blit_pkg::SOURCE_MASK;
    apb(1'b1, blit_pkg::CONTROL_OFS, {13'h0, d16[0], 18'h0});
    apb(1'b1, blit_pkg::COMMAND_OFS, {12'h0, rop[3:0], 12'h0, op[3:0]});
    apb(1'b1, blit_pkg::SOURCE_START_OFS, sa);
    m_op = op;
    m_rop = rop;
    m_d16 = d16;
    nwr = 0;
    npush = 0;
    apb(1'b1, blit_pkg::CONTROL_OFS, {13'h0, d16[0], 17'h0, 1'b1});
  endtask : start

  task automatic run(int op, int rop, int d16, int ex_wr);
    logic [31:0] pexp;
    start(op, rop, d16);
    apb(1'b0, blit_pkg::STATUS_OFS, 32'h0);
    chk_reg("busy_running", 32'(op <= 12), rd & 32'h1);
    wait_idle();
    apb(1'b0, blit_pkg::STATUS_OFS, 32'h0);
    chk_reg("busy_done", 32'h0, rd & 32'h1);
    if (ex_wr >= 0)
      chk_reg("writes", 32'(ex_wr), 32'(nwr));
    if (op > 12)
      return;
    chk_reg("op", 32'(op), 32'(op_o));
    chk_reg("xstart", (op inside {[8:11]}) ? rop & 7 : 0, 32'(xs));
    chk_reg("host", 32'(op inside {0, 4, 8, 9}), 32'(hs));
    if (op inside {0, 4, 8, 9})
      chk_reg("align", 32'(sa[0]), 32'(odd));
    pexp = d16 ? {1'b0, sa[20:7], sa[6:4], sa[3:0]}
               : {sa[20:6], sa[5:3], 1'b0, sa[2:0]};
    chk_reg("split", pexp, {pbase, pline, ppix});
  endtask : run

  task automatic used_is(int u, int p);
    repeat (40) @(negedge clk);
    apb(1'b0, blit_pkg::STATUS_OFS, 32'h0);
    chk_reg("fifo_used", 32'(u), 32'(rd[28:24]));
    chk_reg("pushes", 32'(p), 32'(npush));
  endtask : used_is

  initial
  begin
    {psel, pen, pwr, slow, kmatch, paddr, pwdata} = '0;
    rst = 1'b1;
    void'($urandom(32));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, blit_pkg::COMMAND_OFS, 32'h0);
    chk_reg("cmd_reset", blit_pkg::COMMAND_RST, rd);
    apb(1'b0, blit_pkg::SOURCE_START_OFS, 32'h0);
    chk_reg("src_reset", blit_pkg::SOURCE_RST, rd);
    apb(1'b1, blit_pkg::COMMAND_OFS, 32'hFFFF_FFFF);
    apb(1'b0, blit_pkg::COMMAND_OFS, 32'h0);
    chk_reg("cmd_rw", 32'h000F_000F, rd);
    apb(1'b1, blit_pkg::SOURCE_START_OFS, 32'hFFFF_FFFF);
    apb(1'b0, blit_pkg::SOURCE_START_OFS, 32'h0);
    chk_reg("src_rw", 32'h001F_FFFF, rd);
    apb(1'b0, 16'h8100, 32'h0);
    chk_reg("unmapped", 32'h1, {rd[30:0], e});
    for (int op = 0; op < 16; op++)
    begin
      slow <= op[0];
      if (op != 1)
        run(op, $urandom_range(15), $urandom_range(1),
            (op inside {0, 2, 3, 6, 12}) ? 32 : (op > 12) ? 0 : -1);
    end
    foreach (m_rop_list[i])
      run(0, m_rop_list[i], 1, 32);
    kmatch <= 1'b1;
    run(4, 12, 0, 0);
    run(5, 12, 1, 0);
    kmatch <= 1'b0;
    start(1, 0, 0);
    used_is(16, 16);
    apb(1'b1, blit_pkg::FIFO_POP_OFS, 32'h0);
    apb(1'b1, blit_pkg::FIFO_POP_OFS, 32'h0);
    used_is(14, 16);
    apb(1'b1, blit_pkg::CONTROL_OFS, 32'h0000_0001);
    chk_reg("go_busy", 32'h1, 32'(busy));
    apb(1'b1, blit_pkg::FIFO_POP_OFS, 32'h0);
    used_is(16, 19);
    repeat (29) apb(1'b1, blit_pkg::FIFO_POP_OFS, 32'h0);
    wait_idle();
    used_is(0, 32);
    stop_test();
  end

endmodule : tb_blit_command_decode
`default_nettype wire
